// file: bench/slpcg_core_model.sv
// Core-side partner: issues the sleep instruction and a wake interrupt.
// Assumes the bench requests sleep by a one-cycle want_sleep pulse.
`timescale 1ns/1ps
`default_nettype none
module slpcg_core_model #(
    parameter WAKE_AFTER = 6
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic want_sleep,
    input wire logic core_halt,
    input wire logic sleep_active,
    output logic sleep_instr,
    output logic wake_irq
);
    logic [7:0] cnt;
    // Sleep pulse only while running; wake held until core runs again
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 8'h00;
            wake_irq <= 1'b0;
            sleep_instr <= 1'b0;
        end else begin
            sleep_instr <= want_sleep && !core_halt;
            if (!core_halt) begin
                cnt <= 8'h00;
                wake_irq <= 1'b0;
            end else if (sleep_active && cnt != WAKE_AFTER) begin
                cnt <= cnt + 8'h01;
            end else if (sleep_active) begin
                wake_irq <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/slpcg_ctrl_tb.sv
// Self-checking bench for the sleep and clock gating controller.
// Assumes an AHB-Lite master here and the core model as partner.
`timescale 1ns/1ps
`default_nettype none
`include "slpcg_defs.vh"
module slpcg_ctrl_tb;
    localparam SU = 2;
    reg hclk, hresetn, hsel, hwrite, want_sleep, crystal_clk_sel, timer_two_async_select;
    reg adc_enable, comp_enable, comp_uses_ref, debug_link_enable_fuse, wdt_enable, wake_pin_need;
    reg [9:0] haddr;
    reg [1:0] htrans;
    reg [2:0] hsize, brownout_level_fuse;
    reg [31:0] hwdata, q;
    reg [6:0] periph_sel, e;
    wire hready, hreadyout, hresp, sleep_instr, wake_irq, core_halt, sleep_active, vref_en;
    wire clk_en_two_wire, clk_en_timer_two, clk_en_timer_zero, clk_en_timer_one, clk_en_spi;
    wire clk_en_usart, clk_en_adc, clk_en_cpu, clk_en_io, clk_en_adc_dom, clk_en_async;
    wire main_osc_en, comp_active, comp_adc_mux_ok, bod_en, wdt_run, adc_active;
    wire adc_extended_next, input_buf_en, wake_buf_en;
    wire [31:0] hrdata;
    wire [6:0] periph_access_block;
    wire [6:0] vec = {clk_en_two_wire, clk_en_timer_two, clk_en_timer_zero, clk_en_timer_one,
        clk_en_spi, clk_en_usart, clk_en_adc};
    int mismatches, checks, i;
    assign hready = hreadyout;
    slpcg_ctrl #(.STARTUP_CYC(SU)) slpcg_ctrl_inst (.*);
    slpcg_core_model slpcg_core_model_inst (.*);
    // ---------------
    // Shared tasks
    // ---------------
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    // One single word transfer, waits on ready in both phases
    task bus(input w, input [9:0] a, input [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= `SLPCG_HTRANS_NONSEQ; haddr <= a; hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
        chk("response", hresp, 1'b0);
    endtask
    task go_sleep(input [7:0] c);
        bus(1, `SLPCG_ADDR_SLEEP_CTRL, c);
        @(posedge hclk) want_sleep <= 1'b1;
        @(posedge hclk) want_sleep <= 1'b0;
        tick(5);
    endtask
    // Cycles from wake request to core running
    task wake_chk(input int exp);
        int n;
        n = 0;
        while (wake_irq !== 1'b1 && n < 60) begin tick(1); n++; end
        n = 0;
        while (core_halt !== 1'b0 && n < 60) begin tick(1); n++; end
        chk("wake cycles", n, exp);
        bus(1, `SLPCG_ADDR_SLEEP_CTRL, 32'h0);
    endtask
    // ---------------
    // Scenarios
    // ---------------
    task t_regs;
        bus(0, `SLPCG_ADDR_SLEEP_CTRL, 0); chk("ctl reset", q, 32'h0);
        bus(0, `SLPCG_ADDR_CLK_GATE, 0); chk("gate reset", q, 32'h0);
        bus(1, `SLPCG_ADDR_SLEEP_CTRL, 32'hFF);
        bus(0, `SLPCG_ADDR_SLEEP_CTRL, 0); chk("ctl bits", q, 32'h0F);
        bus(1, `SLPCG_ADDR_CLK_GATE, 32'hFF);
        bus(0, `SLPCG_ADDR_CLK_GATE, 0); chk("gate bits", q, 32'hEF);
        bus(1, 10'h3FC, 32'hFF); bus(0, 10'h3FC, 0); chk("unmapped", q, 32'h0);
        bus(0, `SLPCG_ADDR_CORE_STAT, 0); chk("state run", q, 32'h0);
        bus(1, `SLPCG_ADDR_SLEEP_CTRL, 0); bus(1, `SLPCG_ADDR_CLK_GATE, 0);
        $display("test regs done");
    endtask
    task t_gate;
        for (i = 0; i < 8; i++) if (i != 4) begin
            bus(1, `SLPCG_ADDR_CLK_GATE, 32'h1 << i);
            tick(3);
            e = (i > 4) ? (7'h01 << (i - 1)) : (7'h01 << i);
            chk("clock enables", vec, e ^ 7'h7F);
            chk("access block", periph_access_block, e);
            chk("mux ok", comp_adc_mux_ok, i != 0);
        end
        @(posedge hclk) periph_sel <= 7'h3F;
        tick(3); chk("access unsel", periph_access_block, 7'h00);
        @(posedge hclk) periph_sel <= 7'h7F;
        bus(1, `SLPCG_ADDR_CLK_GATE, 0); tick(3); chk("restart", vec, 7'h7F);
        timer_two_async_select <= 1'b1; bus(1, `SLPCG_ADDR_CLK_GATE, 32'h40); tick(5);
        chk("async timer", clk_en_timer_two, 1'b1);
        bus(1, `SLPCG_ADDR_CLK_GATE, 0); timer_two_async_select <= 1'b0;
        $display("test gate done");
    endtask
    task t_refuse;
        reg [7:0] c;
        for (i = 0; i < 5; i++) begin
            case (i)
                0: c = 8'h09;
                1: c = 8'h0B;
                2: c = 8'h0F;
                3: c = 8'h0C;
                default: c = 8'h0D;
            endcase
            crystal_clk_sel <= (i != 4);
            go_sleep(c); chk("no sleep", core_halt, 1'b0);
        end
        crystal_clk_sel <= 1'b1;
        $display("test refuse done");
    endtask
    task t_modes;
        comp_enable <= 1'b1; adc_enable <= 1'b1; bus(1, `SLPCG_ADDR_CLK_GATE, 32'h20);
        go_sleep(8'h01);
        chk("idle io", clk_en_io, 1'b1); chk("idle cpu", clk_en_cpu, 1'b0);
        chk("gated t0", clk_en_timer_zero, 1'b0); chk("free t1", clk_en_timer_one, 1'b1);
        chk("idle comp", comp_active, 1'b1); chk("adc kept", adc_active, 1'b1);
        chk("adc ext", adc_extended_next, 1'b0);
        bus(0, `SLPCG_ADDR_CORE_STAT, 0); chk("state sleep", q, 32'h1);
        wake_chk(9);
        bus(1, `SLPCG_ADDR_CLK_GATE, 0); tick(3); chk("t0 back", clk_en_timer_zero, 1'b1);
        go_sleep(8'h03);
        chk("nr io", clk_en_io, 1'b0); chk("nr adc dom", clk_en_adc_dom, 1'b1);
        chk("nr comp", comp_active, 1'b1); chk("nr buf", input_buf_en, 1'b1);
        wake_chk(9);
        comp_uses_ref <= 1'b1; debug_link_enable_fuse <= 1'b1; go_sleep(8'h07);
        chk("save comp", comp_active, 1'b0); chk("ref kept", vref_en, 1'b1);
        chk("debug osc", main_osc_en, 1'b1);
        wake_chk(9 + SU - 1);
        comp_enable <= 1'b0; comp_uses_ref <= 1'b0; adc_enable <= 1'b0;
        debug_link_enable_fuse <= 1'b0; wdt_enable <= 1'b1;
        brownout_level_fuse <= 3'h4; wake_pin_need <= 1'b1; go_sleep(8'h05);
        chk("pd osc", main_osc_en, 1'b0); chk("pd async", clk_en_async, 1'b0);
        chk("pd wdt", wdt_run, 1'b1); chk("pd bod", bod_en, 1'b1);
        chk("pd buf", input_buf_en, 1'b0); chk("wake buf", wake_buf_en, 1'b1);
        chk("pd adc dom", clk_en_adc_dom, 1'b0); chk("ext pending", adc_extended_next, 1'b1);
        wake_chk(9 + SU - 1);
        go_sleep(8'h0D);
        chk("sb io", clk_en_io, 1'b0); chk("sb osc", main_osc_en, 1'b1);
        wake_chk(9);
        $display("test modes done");
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        hclk = 0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        #100000;
        mismatches++;
        results;
    end
    initial begin
        {hsel, hwrite, want_sleep, timer_two_async_select, adc_enable, comp_enable} = 0;
        {comp_uses_ref, debug_link_enable_fuse, wdt_enable, wake_pin_need} = 0;
        {haddr, htrans, hwdata, brownout_level_fuse} = 0;
        hresetn = 0; crystal_clk_sel = 1; hsize = 3'h2; periph_sel = 7'h7F;
        mismatches = 0; checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_gate;
        t_refuse;
        t_modes;
        results;
    end
endmodule
`default_nettype wire

// file: bench/slpcg_monitor.sv
// Concurrent checks on the ports of the sleep and clock gating controller.
// Assumes binding into slpcg_ctrl; one clock domain, hclk with hresetn.
`timescale 1ns/1ps
`default_nettype none
module slpcg_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [6:0] periph_sel,
    input wire logic [6:0] periph_access_block,
    input wire logic core_halt,
    input wire logic sleep_active,
    input wire logic clk_en_cpu,
    input wire logic clk_en_io,
    input wire logic clk_en_adc_dom,
    input wire logic main_osc_en,
    input wire logic input_buf_en,
    input wire logic debug_link_enable_fuse,
    input wire logic wdt_enable,
    input wire logic wdt_run,
    input wire logic [2:0] brownout_level_fuse,
    input wire logic bod_en,
    input wire logic adc_enable,
    input wire logic comp_enable,
    input wire logic comp_uses_ref,
    input wire logic vref_en,
    input wire logic adc_active,
    input wire logic adc_extended_next
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Halt held a few cycles after leaving sleep, then run
    sequence halt_then_run;
        core_halt [*3] ##[1:2] !core_halt;
    endsequence
    halt_release_a: assert property ($fell(sleep_active) |-> halt_then_run)
        else $error("core not held after wake");
    access_block_a: assert property (1 |=> (periph_access_block & ~$past(periph_sel)) == 7'h00)
        else $error("access blocked for unaddressed unit");
    input_buf_a: assert property ((!clk_en_io && !clk_en_adc_dom) [*3] |-> !input_buf_en)
        else $error("input buffers on with clocks stopped");
    debug_osc_a: assert property ((debug_link_enable_fuse && sleep_active) [*5] |-> main_osc_en)
        else $error("main clock off in sleep with debug on");
    wdt_keep_a: assert property (wdt_enable [*5] |-> wdt_run)
        else $error("watchdog stopped");
    bod_keep_a: assert property ((brownout_level_fuse != 3'h0) [*5] |-> bod_en)
        else $error("brown-out detector off");
    vref_off_a: assert property ((!adc_enable && !comp_enable && brownout_level_fuse == 3'h0) [*5]
        |-> !vref_en)
        else $error("reference on with no user");
    vref_hold_a: assert property ((comp_enable && comp_uses_ref) [*5] |-> vref_en)
        else $error("reference off while comparator uses it");
    adc_keep_a: assert property (adc_enable [*5] |-> adc_active)
        else $error("converter dropped");
    adc_ext_a: assert property ((!adc_enable) [*5] |-> adc_extended_next)
        else $error("extended conversion not pending");
    pdown_clk_a: assert property ((!main_osc_en) [*2] |-> !clk_en_cpu && !clk_en_io)
        else $error("clock runs with oscillator off");
endmodule
bind slpcg_ctrl slpcg_monitor slpcg_monitor_inst (.*);
`default_nettype wire

// file: rtl/slpcg_ctrl.v
// Sleep mode control and per-peripheral clock gating, with AHB-Lite registers.
// Assumes one AHB-Lite master, word transfers, and a core that pulses sleep_instr.
//
// Functional notes
// - Code 110 with crystal clock enters standby; oscillator keeps running.
// - Standby wake-up completes within six clock cycles.
// - Gate bit set stops peripheral clock, freezes state, blocks register access.
// - Gate bit cleared restarts clock; peripheral resumes from frozen state.
// - Gating acts in active and idle, and bit 0 also in ADC noise reduction; deeper modes stop clocks anyway.
// - Enabled ADC stays enabled in sleep; off-then-on forces extended conversion.
// - Comparator auto-disabled in sleep other than idle and ADC noise reduction.
// - Comparator using internal reference keeps reference on in every mode.
// - Reference on only while brown-out, comparator or ADC needs it.
// - Fuse-enabled brown-out detector stays enabled in every sleep mode.
// - Enabled watchdog keeps running in every sleep mode.
// - Input buffers off when I/O and ADC clocks stop, except wake pins.
// - Debug fuse keeps main clock source on during sleep.
// - Mode field bits 3..1; five codes valid, 100, 101, 111 reserved.
// - Sleep instruction sleeps only when enable bit 0 is one.
// - Sleep control bits 7..4 read zero.
// - Bit 7 stops the two-wire unit clock; software reinitialises it.
// - Bit 6 gates timer two only in synchronous mode.
// - Bits 5 and 3 gate timers zero and one; bit 4 reads zero.
// - Bit 2 gates SPI, bit 1 USART; avoid bit 2 while debugging.
// - Bit 0 gates ADC; comparator loses ADC multiplexer while gated.
// - Interrupt wake holds core four cycles beyond start-up time.
// - Power-down halts all generated clocks; only async modules run.
`timescale 1ns/1ps
`default_nettype none
`include "slpcg_defs.vh"

module slpcg_ctrl #(
    parameter STARTUP_CYC = 16
) (
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [9:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire hready,
    // Core side
    input wire sleep_instr,
    input wire wake_irq,
    input wire crystal_clk_sel,
    output reg core_halt,
    output reg sleep_active,
    // Peripheral clock enables
    output reg clk_en_two_wire,
    output reg clk_en_timer_two,
    output reg clk_en_timer_zero,
    output reg clk_en_timer_one,
    output reg clk_en_spi,
    output reg clk_en_usart,
    output reg clk_en_adc,
    // Clock domain enables
    output reg clk_en_cpu,
    output reg clk_en_io,
    output reg clk_en_adc_dom,
    output reg clk_en_async,
    output reg main_osc_en,
    // Peripheral register access blocking
    input wire [6:0] periph_sel,
    output reg [6:0] periph_access_block,
    // Analog and system helpers
    input wire timer_two_async_select,
    input wire adc_enable,
    input wire comp_enable,
    input wire comp_uses_ref,
    input wire [2:0] brownout_level_fuse,
    input wire debug_link_enable_fuse,
    input wire wdt_enable,
    input wire wake_pin_need,
    output reg comp_active,
    output reg comp_adc_mux_ok,
    output reg vref_en,
    output reg bod_en,
    output reg wdt_run,
    output reg adc_active,
    output reg adc_extended_next,
    output reg input_buf_en,
    output reg wake_buf_en
);

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
localparam NSYNC = 10;
wire [NSYNC-1:0] async_in;
reg [NSYNC-1:0] sync_a;
reg [NSYNC-1:0] sync_b;
assign async_in = {wake_irq, crystal_clk_sel, timer_two_async_select, adc_enable,
    comp_enable, comp_uses_ref, (|brownout_level_fuse), debug_link_enable_fuse,
    wdt_enable, wake_pin_need};

// Two stages for pins and analog-side levels
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        sync_a <= {NSYNC{1'b0}};
        sync_b <= {NSYNC{1'b0}};
    end else begin
        sync_a <= async_in;
        sync_b <= sync_a;
    end
end

// Synchronised levels, named by use
wire s_wake = sync_b[9];
wire s_xtal = sync_b[8];
wire s_t2as = sync_b[7];
wire s_adc = sync_b[6];
wire s_comp = sync_b[5];
wire s_cref = sync_b[4];
wire s_bod = sync_b[3];
wire s_dbg = sync_b[2];
wire s_wdt = sync_b[1];
wire s_wpin = sync_b[0];

// ----------------------------------------------------------------
// AHB-Lite slave
// ----------------------------------------------------------------
// Register file and pending write
reg [7:0] sleep_control_reg;
reg [7:0] peripheral_clock_gate_reg;
reg wr_pend;
reg [9:0] wr_addr;
reg [2:0] slp_state;

// Transfer taken on a selected, ready NONSEQ cycle
wire addr_ph = hsel && hready && (htrans == `SLPCG_HTRANS_NONSEQ);

// Address phase capture, zero-wait data phase
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend <= 1'b0;
        wr_addr <= 10'h000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        wr_pend <= addr_ph && hwrite;
        if (addr_ph) begin
            wr_addr <= haddr;
        end
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end
end

// Read data registered at the address phase
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h00000000;
    end else if (addr_ph && !hwrite) begin
        case (haddr)
            `SLPCG_ADDR_SLEEP_CTRL: begin
                hrdata <= {24'h000000, sleep_control_reg & `SLPCG_SLEEP_CTRL_WMASK};
            end
            `SLPCG_ADDR_CLK_GATE: begin
                hrdata <= {24'h000000, peripheral_clock_gate_reg};
            end
            `SLPCG_ADDR_CORE_STAT: begin
                hrdata <= {29'h00000000, slp_state};
            end
            default: begin
                hrdata <= 32'h00000000;
            end
        endcase
    end
end

// Register writes in the data phase; reserved bits masked
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        sleep_control_reg <= `SLPCG_SLEEP_CTRL_RST;
        peripheral_clock_gate_reg <= `SLPCG_CLK_GATE_RST;
    end else if (wr_pend) begin
        if (wr_addr == `SLPCG_ADDR_SLEEP_CTRL) begin
            sleep_control_reg <= hwdata[7:0] & `SLPCG_SLEEP_CTRL_WMASK;
        end
        if (wr_addr == `SLPCG_ADDR_CLK_GATE) begin
            peripheral_clock_gate_reg <= hwdata[7:0] & `SLPCG_CLK_GATE_WMASK;
        end
    end
end

// ----------------------------------------------------------------
// Sleep sequencer
// ----------------------------------------------------------------
// Sequencer states
localparam ST_RUN = 3'h0;
localparam ST_SLEEP = 3'h1;
localparam ST_START = 3'h2;
localparam ST_HALT = 3'h3;

// Mode decode; standby refused without a crystal clock
wire [2:0] mode = sleep_control_reg[`SLPCG_SM_HI:`SLPCG_SM_LO];
wire mode_valid = (mode == `SLPCG_SM_IDLE) || (mode == `SLPCG_SM_ADCNR) ||
    (mode == `SLPCG_SM_PDOWN) || (mode == `SLPCG_SM_PSAVE) ||
    ((mode == `SLPCG_SM_STBY) && s_xtal);
// Mode latched at entry; later writes do not disturb a sleep
reg [2:0] cur_mode;
reg [15:0] cnt;
reg [2:0] next_state;
reg [15:0] next_cnt;

// Wake delay: standby reaches run within six cycles
wire [15:0] start_cyc = (cur_mode == `SLPCG_SM_STBY || cur_mode == `SLPCG_SM_IDLE ||
    cur_mode == `SLPCG_SM_ADCNR) ? `SLPCG_FAST_START_CYC : STARTUP_CYC[15:0];

// Next state: sleep, start-up count, fixed halt, run
always @* begin
    next_state = slp_state;
    next_cnt = cnt;
    case (slp_state)
        ST_RUN: begin
            if (sleep_instr && sleep_control_reg[`SLPCG_SE_BIT] && mode_valid) begin
                next_state = ST_SLEEP;
            end
        end
        ST_SLEEP: begin
            if (s_wake) begin
                next_state = ST_START;
                next_cnt = start_cyc;
            end
        end
        ST_START: begin
            if (cnt <= 16'h0001) begin
                next_state = ST_HALT;
                next_cnt = {12'h000, `SLPCG_HALT_EXTRA_CYC};
            end else begin
                next_cnt = cnt - 16'h0001;
            end
        end
        ST_HALT: begin
            if (cnt <= 16'h0001) begin
                next_state = ST_RUN;
            end else begin
                next_cnt = cnt - 16'h0001;
            end
        end
        default: begin
            next_state = ST_RUN;
        end
    endcase
end

// State, counter and latched mode
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        slp_state <= ST_RUN;
        cnt <= 16'h0000;
        cur_mode <= `SLPCG_SM_IDLE;
    end else begin
        slp_state <= next_state;
        cnt <= next_cnt;
        if (slp_state == ST_RUN) begin
            cur_mode <= mode;
        end
    end
end

// ----------------------------------------------------------------
// Clock domains and peripheral gates
// ----------------------------------------------------------------
// Sequencer state decoded per latched mode
wire in_sleep = (slp_state == ST_SLEEP) || (slp_state == ST_START);
wire asleep = (slp_state == ST_SLEEP);
wire m_idle = asleep && (cur_mode == `SLPCG_SM_IDLE);
wire m_adcnr = asleep && (cur_mode == `SLPCG_SM_ADCNR);
wire m_psave = asleep && (cur_mode == `SLPCG_SM_PSAVE);
wire m_stby = asleep && (cur_mode == `SLPCG_SM_STBY);
// Domain levels follow the mode table
wire io_on = !asleep || m_idle;
wire adcd_on = !asleep || m_idle || m_adcnr;
// Gate bits as written by software
wire [7:0] g = peripheral_clock_gate_reg;
// Timer two gate honoured only when it runs synchronously
wire t2_gate = g[`SLPCG_G_TIM2] && !s_t2as;
wire t2_on = s_t2as ? (!asleep || m_idle || m_adcnr || m_psave) : (io_on && !t2_gate);
wire [6:0] gate_vec = {g[`SLPCG_G_TWI], t2_gate, g[`SLPCG_G_TIM0], g[`SLPCG_G_TIM1],
    g[`SLPCG_G_SPI], g[`SLPCG_G_USART], g[`SLPCG_G_ADC]};
// Converter state one cycle back, for the extended flag
reg adc_was_on;

// Domain and peripheral enables, registered
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        clk_en_cpu <= 1'b1;
        clk_en_io <= 1'b1;
        clk_en_adc_dom <= 1'b1;
        clk_en_async <= 1'b1;
        main_osc_en <= 1'b1;
        sleep_active <= 1'b0;
        core_halt <= 1'b0;
        clk_en_two_wire <= 1'b1;
        clk_en_timer_two <= 1'b1;
        clk_en_timer_zero <= 1'b1;
        clk_en_timer_one <= 1'b1;
        clk_en_spi <= 1'b1;
        clk_en_usart <= 1'b1;
        clk_en_adc <= 1'b1;
        periph_access_block <= 7'h00;
    end else begin
        clk_en_cpu <= (slp_state == ST_RUN);
        core_halt <= (slp_state != ST_RUN);
        sleep_active <= in_sleep;
        clk_en_io <= io_on;
        clk_en_adc_dom <= adcd_on;
        clk_en_async <= !asleep || m_idle || m_adcnr || m_psave;
        main_osc_en <= !asleep || m_idle || m_adcnr || m_stby || s_dbg;
        clk_en_two_wire <= io_on && !g[`SLPCG_G_TWI];
        clk_en_timer_two <= t2_on;
        clk_en_timer_zero <= io_on && !g[`SLPCG_G_TIM0];
        clk_en_timer_one <= io_on && !g[`SLPCG_G_TIM1];
        clk_en_spi <= io_on && !g[`SLPCG_G_SPI];
        clk_en_usart <= io_on && !g[`SLPCG_G_USART];
        clk_en_adc <= adcd_on && !g[`SLPCG_G_ADC];
        periph_access_block <= gate_vec & periph_sel;
    end
end

// ----------------------------------------------------------------
// Analog helpers, watchdog, buffers
// ----------------------------------------------------------------
wire adc_on_now = s_adc && !g[`SLPCG_G_ADC];
wire comp_on_now = s_comp && (!asleep || m_idle || m_adcnr);

// Helper levels registered so each output leaves a flip-flop
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        comp_active <= 1'b0;
        comp_adc_mux_ok <= 1'b1;
        vref_en <= 1'b0;
        bod_en <= 1'b0;
        wdt_run <= 1'b0;
        adc_active <= 1'b0;
        adc_extended_next <= 1'b1;
        adc_was_on <= 1'b0;
        input_buf_en <= 1'b1;
        wake_buf_en <= 1'b1;
    end else begin
        comp_active <= comp_on_now;
        comp_adc_mux_ok <= !g[`SLPCG_G_ADC];
        // Reference follows its users; comparator use holds it in any mode
        vref_en <= s_bod || adc_on_now || (s_comp && s_cref);
        bod_en <= s_bod;
        wdt_run <= s_wdt;
        adc_active <= adc_on_now;
        adc_was_on <= adc_on_now;
        // Extended conversion after any off-to-on of the converter
        if (!adc_was_on && adc_on_now) begin
            adc_extended_next <= 1'b1;
        end else if (!adc_on_now) begin
            adc_extended_next <= 1'b1;
        end else begin
            adc_extended_next <= 1'b0;
        end
        input_buf_en <= io_on || adcd_on;
        wake_buf_en <= io_on || adcd_on || s_wpin;
    end
end

endmodule
`default_nettype wire

// file: rtl/slpcg_defs.vh
// Constants for the sleep and clock gating controller.
// Assumes inclusion by the design and the bench; definitions only.
`ifndef SLPCG_DEFS_VH
`define SLPCG_DEFS_VH

// Register indices and byte addresses; byte address is four times the index
`define SLPCG_IDX_SLEEP_CTRL 8'h53
`define SLPCG_IDX_CLK_GATE 8'h64
`define SLPCG_IDX_CORE_STAT 8'h70
`define SLPCG_ADDR_SLEEP_CTRL 10'h14C
`define SLPCG_ADDR_CLK_GATE 10'h190
`define SLPCG_ADDR_CORE_STAT 10'h1C0

// Reset values
`define SLPCG_SLEEP_CTRL_RST 8'h00
`define SLPCG_CLK_GATE_RST 8'h00

// Sleep control fields
`define SLPCG_SE_BIT 0
`define SLPCG_SM_HI 3
`define SLPCG_SM_LO 1
`define SLPCG_SLEEP_CTRL_WMASK 8'h0F

// Clock gate fields
`define SLPCG_G_TWI 7
`define SLPCG_G_TIM2 6
`define SLPCG_G_TIM0 5
`define SLPCG_G_TIM1 3
`define SLPCG_G_SPI 2
`define SLPCG_G_USART 1
`define SLPCG_G_ADC 0
`define SLPCG_CLK_GATE_WMASK 8'hEF

// Sleep mode codes
`define SLPCG_SM_IDLE 3'h0
`define SLPCG_SM_ADCNR 3'h1
`define SLPCG_SM_PDOWN 3'h2
`define SLPCG_SM_PSAVE 3'h3
`define SLPCG_SM_STBY 3'h6

// Timing, in clock cycles of hclk
`define SLPCG_STBY_WAKE_CYC 4'h6
`define SLPCG_HALT_EXTRA_CYC 4'h4
`define SLPCG_FAST_START_CYC 16'h0001

// AHB transfer type
`define SLPCG_HTRANS_NONSEQ 2'h2

`endif
